// file: src/spp_top.sv
// Two-channel stepper motor and bit pattern port with APB registers
//
// Operation
// [RULE1] Two independent 4-bit channels, identical except trigger sources.
// [RULE2] Channel zero triggers from timer pair zero/one, or wide timer.
// [RULE3] Channel one triggers from timer pair two/three, or wide timer.
// [RULE4] Trigger enable bit gates timer triggers per channel; resets to 0.
// [RULE5] Mode bit 0 means full step, 1 means half step or pattern.
// [RULE6] Direction bit 1 reverses the shift order of output bits.
// [RULE7] Write mode bit picks 8-bit or 4-bit channel writes; resets 0.
// [RULE8] Control register: channel one in bits 7..4, zero in 3..0.
// [RULE9] Software writes whole channel values, never read-modify-write.
// [RULE10] Pattern mode blocks latch writes; only alternate bits written.
// [RULE11] Pattern mode needs mode bit one and direction bit zero.
// [RULE12] Software refills alternate bits before the next trigger.
// [RULE13] Each pin carries pattern output only when selected per pin.
// [RULE14] Full step sequence uses only the upper four register bits.
// [RULE15] Each enabled trigger shifts the latch and drives the port.
// [RULE16] One or two adjacent ones give one or two phase; alt ignored.
// [RULE17] Half step shifts latch and alternate as interleaved 8-bit ring.
// [RULE18] Wide timer trigger occurs only on match with compare b.
// [RULE19] Without an enabled trigger the channel state holds.
// [RULE20] Each one-cycle trigger pulse advances exactly one step.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "spp_cfg.svh"

module spp_top
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   input wire logic tmr01_trig_i,
   input wire logic tmr23_trig_i,
   input wire logic wide_timer_compare_b_match_i,
   input wire logic [7:0] port_function_select_i,
   output logic [7:0] pattern_pin_o,
   output logic [7:0] pattern_pin_oe_o,
   output logic compare_double_buffer_enable_o
);

   // ----------------------------------------------------------------
   // State and its next value
   // ----------------------------------------------------------------
   spp_pkg::spp_state_t state_ff;
   spp_pkg::spp_state_t nxt_state;

   // Per-channel results of one shift step
   logic [1:0] chan_fire;
   logic [1:0][3:0] step_latch;
   logic [1:0][3:0] step_alt;

   // Bus decode
   spp_pkg::spp_sel_t bus_sel;
   logic bus_setup;
   logic bus_access;
   logic [9:0] bus_idx;
   logic [31:0] read_word;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------

   // Setup and access phases of an APB transfer
   assign bus_setup = psel_i & ~penable_i;
   assign bus_access = psel_i & penable_i;
   assign bus_idx = paddr_i[`SPP_ADDR_W-1:`SPP_IDX_LSB];

   // Map the word index onto a register
   always_comb
   begin
      bus_sel = spp_pkg::SPP_SEL_NONE;
      if (paddr_i[`SPP_IDX_LSB-1:0] == `SPP_WORD_OFS)
      begin
         case (bus_idx)
            `SPP_IDX_TSEL: bus_sel = spp_pkg::SPP_SEL_TSEL;
            `SPP_IDX_CH0: bus_sel = spp_pkg::SPP_SEL_CH0;
            `SPP_IDX_CH1: bus_sel = spp_pkg::SPP_SEL_CH1;
            `SPP_IDX_CTRL: bus_sel = spp_pkg::SPP_SEL_CTRL;
            default: bus_sel = spp_pkg::SPP_SEL_NONE;
         endcase
      end
   end

   // Read data for the addressed register, upper bits zero
   always_comb
   begin
      case (bus_sel)
         spp_pkg::SPP_SEL_TSEL:
         begin
            read_word = {{`SPP_PAD_W{1'b0}}, state_ff.tsel};
         end
         spp_pkg::SPP_SEL_CH0:
         begin
            read_word = {{`SPP_PAD_W{1'b0}},
                         state_ff.latch[0], state_ff.alt[0]};
         end
         spp_pkg::SPP_SEL_CH1:
         begin
            read_word = {{`SPP_PAD_W{1'b0}},
                         state_ff.latch[1], state_ff.alt[1]};
         end
         spp_pkg::SPP_SEL_CTRL:
         begin
            read_word = {{`SPP_PAD_W{1'b0}}, state_ff.ctrl};
         end
         default:
         begin
            read_word = `SPP_RDATA_RST;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Per-channel trigger and shift step
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `SPP_NCH; g = g + 1)
      begin : g_chan
         logic eight_bit_trig;
         logic src_wide;
         logic trig_raw;
         logic trig_en;
         logic half;
         logic rev;
         logic [3:0] l;
         logic [3:0] a;
         logic [7:0] ring;
         logic [7:0] ring_nxt;
         logic [3:0] sh_latch;
         logic [3:0] sh_alt;

         // Channel zero uses timers 0/1, channel one timers 2/3
         if (g == 0)
         begin : g_src0
            assign eight_bit_trig = tmr01_trig_i; // RULE2
         end
         else
         begin : g_src1
            assign eight_bit_trig = tmr23_trig_i; // RULE3
         end

         // Source select and enable gate
         assign src_wide = state_ff.tsel[`SPP_TSEL_SRC_BASE + g];
         assign trig_raw = src_wide ? wide_timer_compare_b_match_i // RULE18
                                    : eight_bit_trig; // RULE2 RULE3
         assign trig_en = state_ff.ctrl[g*`SPP_CTL_NIB + `SPP_CTL_TE];
         assign chan_fire[g] = trig_raw & trig_en; // RULE4 RULE20
         assign half = state_ff.ctrl[g*`SPP_CTL_NIB + `SPP_CTL_HALF];
         assign rev = state_ff.ctrl[g*`SPP_CTL_NIB + `SPP_CTL_REV];
         assign l = state_ff.latch[g];
         assign a = state_ff.alt[g];

         // Interleaved ring, latch bit above its alternate bit
         assign ring = {l[3], a[3], l[2], a[2],
                        l[1], a[1], l[0], a[0]}; // RULE17
         assign ring_nxt = rev ? {ring[0], ring[7:1]}
                               : {ring[6:0], ring[7]}; // RULE6 RULE17

         // Full step rotates the latch alone; half step the ring
         always_comb
         begin
            if (half) // RULE5
            begin
               sh_latch = {ring_nxt[7], ring_nxt[5],
                           ring_nxt[3], ring_nxt[1]};
               sh_alt = {ring_nxt[6], ring_nxt[4],
                         ring_nxt[2], ring_nxt[0]};
            end
            else
            begin
               sh_latch = rev ? {l[0], l[3:1]} // RULE6
                              : {l[2:0], l[3]}; // RULE14 RULE16
               sh_alt = a; // RULE16
            end
         end

         // One driver per channel slice of the step results
         assign step_latch[g] = sh_latch;
         assign step_alt[g] = sh_alt;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   // Shift on triggers, then apply a bus write over it
   always_comb
   begin
      nxt_state = state_ff;

      // Advance each fired channel by one step, else hold
      for (int c = 0; c < `SPP_NCH; c++)
      begin
         if (chan_fire[c]) // RULE15 RULE1
         begin
            nxt_state.latch[c] = step_latch[c];
            nxt_state.alt[c] = step_alt[c];
         end
         else
         begin
            nxt_state.latch[c] = state_ff.latch[c]; // RULE19
            nxt_state.alt[c] = state_ff.alt[c]; // RULE19
         end
      end

      // Register writes take effect in the access phase
      if (bus_access && pwrite_i)
      begin
         case (bus_sel)
            spp_pkg::SPP_SEL_TSEL:
            begin
               nxt_state.tsel = pwdata_i[7:0] & `SPP_TSEL_MASK;
            end
            spp_pkg::SPP_SEL_CTRL:
            begin
               nxt_state.ctrl = pwdata_i[7:0]; // RULE8
            end
            spp_pkg::SPP_SEL_CH0:
            begin
               nxt_state.alt[0] = pwdata_i[3:0];
               if (!state_ff.ctrl[`SPP_CTL_WW]) // RULE7 RULE10
               begin
                  nxt_state.latch[0] = pwdata_i[7:4];
               end
            end
            spp_pkg::SPP_SEL_CH1:
            begin
               nxt_state.alt[1] = pwdata_i[3:0];
               if (!state_ff.ctrl[`SPP_CTL_NIB + `SPP_CTL_WW]) // RULE7
               begin
                  nxt_state.latch[1] = pwdata_i[7:4]; // RULE10
               end
            end
            default:
            begin
               nxt_state.tsel = state_ff.tsel;
            end
         endcase
      end

      // Read data is captured in the setup phase
      if (bus_setup && !pwrite_i)
      begin
         nxt_state.rdata = read_word;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // All state resets to constants
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_ff.tsel <= `SPP_TSEL_RST;
         state_ff.ctrl <= `SPP_CTRL_RST; // RULE4 RULE7 RULE8
         state_ff.latch <= {`SPP_NCH{`SPP_LATCH_RST}};
         state_ff.alt <= {`SPP_NCH{`SPP_ALT_RST}};
         state_ff.rdata <= `SPP_RDATA_RST;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Zero-wait answer; error on unmapped address
   assign pready_o = 1'b1;
   assign pslverr_o = bus_access & (bus_sel == spp_pkg::SPP_SEL_NONE);
   assign prdata_o = state_ff.rdata;

   // Output latches drive the pins, enabled pin by pin
   assign pattern_pin_o = {state_ff.latch[1], state_ff.latch[0]}; // RULE15
   assign pattern_pin_oe_o = port_function_select_i; // RULE13

   // Double buffer enable for the wide timer compare
   assign compare_double_buffer_enable_o = state_ff.tsel[`SPP_TSEL_DB];

endmodule

// file: src/spp_cfg.svh
// Constants of the stepper pattern port: offsets, fields, reset values
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SPP_IDX_TSEL 10'h03A
`define SPP_IDX_CH0 10'h04C
`define SPP_IDX_CH1 10'h04D
`define SPP_IDX_CTRL 10'h04E
`define SPP_ADDR_W 12
`define SPP_IDX_LSB 2
`define SPP_WORD_OFS 2'h0

// ----------------------------------------------------------------
// Trigger select register fields
// ----------------------------------------------------------------
`define SPP_TSEL_DB 0
`define SPP_TSEL_SRC_BASE 2
`define SPP_TSEL_MASK 8'h8D
`define SPP_TSEL_RST 8'h00

// ----------------------------------------------------------------
// Control register fields, per channel nibble
// ----------------------------------------------------------------
`define SPP_CTL_NIB 4
`define SPP_CTL_TE 0
`define SPP_CTL_HALF 1
`define SPP_CTL_REV 2
`define SPP_CTL_WW 3
`define SPP_CTRL_RST 8'h00

// ----------------------------------------------------------------
// Channel register layout and reset values
// ----------------------------------------------------------------
`define SPP_NCH 2
`define SPP_LATCH_RST 4'h0
`define SPP_ALT_RST 4'h0
`define SPP_RDATA_RST 32'h0000_0000
`define SPP_PAD_W 24

`endif

// file: src/spp_pkg.sv
// Types shared by the stepper pattern port
package spp_pkg;

   // ----------------------------------------------------------------
   // Register select decoded from the bus address
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      SPP_SEL_NONE,
      SPP_SEL_TSEL,
      SPP_SEL_CH0,
      SPP_SEL_CH1,
      SPP_SEL_CTRL
   } spp_sel_t;

   // ----------------------------------------------------------------
   // Complete state of the block
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0] tsel;
      logic [7:0] ctrl;
      logic [1:0][3:0] latch;
      logic [1:0][3:0] alt;
      logic [31:0] rdata;
   } spp_state_t;

endpackage

// file: testbench/spp_sva.sv
// Port checker of the stepper pattern port
`timescale 1ns/10ps
module spp_sva
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic tmr01_trig_i,
   input wire logic tmr23_trig_i,
   input wire logic wide_timer_compare_b_match_i,
   input wire logic [7:0] port_function_select_i,
   input wire logic [7:0] pattern_pin_o,
   input wire logic [7:0] pattern_pin_oe_o,
   input wire logic compare_double_buffer_enable_o
);
   logic [7:0] ctl_ff;
   logic [7:0] sel_ff;
   logic wa;
   logic w0;
   logic w1;
   logic g0;
   logic g1;
   logic [3:0] p0;
   logic [3:0] p1;
   logic [3:0] wd;
   // Strobes, channel gates and per-channel pin and data slices
   assign wa = psel_i & penable_i & pwrite_i;
   assign w0 = wa & (paddr_i == 12'h130);
   assign w1 = wa & (paddr_i == 12'h134);
   assign g0 = ctl_ff[0] &
      (sel_ff[2] ? wide_timer_compare_b_match_i : tmr01_trig_i);
   assign g1 = ctl_ff[4] &
      (sel_ff[3] ? wide_timer_compare_b_match_i : tmr23_trig_i);
   assign p0 = pattern_pin_o[3:0];
   assign p1 = pattern_pin_o[7:4];
   assign wd = pwdata_i[7:4];
   // Shadow copies of control and trigger select
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
      if (!reset_n_i)
      begin
         ctl_ff <= 8'h00;
         sel_ff <= 8'h00;
      end
      else
      begin
         if (wa && paddr_i == 12'h138)
            ctl_ff <= pwdata_i[7:0];
         if (wa && paddr_i == 12'h0E8)
            sel_ff <= pwdata_i[7:0];
      end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_hold_idle: assert property (
      !g0 && !w0 |=> $stable(p0)) else $error("channel zero drifted");
   chk_full_left: assert property (
      g0 && !ctl_ff[1] && !ctl_ff[2] && !w0 |=>
      p0 == {$past(p0[2:0]), $past(p0[3])}) else $error("bad step");
   chk_full_right: assert property (
      g0 && !ctl_ff[1] && ctl_ff[2] && !w0 |=>
      p0 == {$past(p0[0]), $past(p0[3:1])}) else $error("bad reverse");
   chk_ch1_step: assert property (
      g1 && !ctl_ff[5] && !ctl_ff[6] && !w1 |=>
      p1 == {$past(p1[2:0]), $past(p1[3])}) else $error("bad step one");
   chk_src_select: assert property (
      sel_ff[2] && tmr01_trig_i && !wide_timer_compare_b_match_i && !w0
      |=> $stable(p0)) else $error("wrong trigger source");
   chk_pin_enable: assert property (
      pattern_pin_oe_o == port_function_select_i) else $error("bad oe");
   chk_ctrl_read: assert property (
      psel_i && penable_i && !pwrite_i && paddr_i == 12'h138 |->
      prdata_o == {24'h000000, ctl_ff}) else $error("bad control read");
   chk_latch_kept: assert property (
      w0 && ctl_ff[3] && !g0 |=> $stable(p0)) else $error("latch written");
   chk_latch_load: assert property (
      w0 && !ctl_ff[3] |=> p0 == $past(wd)) else $error("latch not loaded");
endmodule
bind spp_top spp_sva CHK
(
   .ref_clk_i(ref_clk_i),
   .reset_n_i(reset_n_i),
   .psel_i(psel_i),
   .penable_i(penable_i),
   .pwrite_i(pwrite_i),
   .paddr_i(paddr_i),
   .pwdata_i(pwdata_i),
   .pready_o(pready_o),
   .prdata_o(prdata_o),
   .pslverr_o(pslverr_o),
   .tmr01_trig_i(tmr01_trig_i),
   .tmr23_trig_i(tmr23_trig_i),
   .wide_timer_compare_b_match_i(wide_timer_compare_b_match_i),
   .port_function_select_i(port_function_select_i),
   .pattern_pin_o(pattern_pin_o),
   .pattern_pin_oe_o(pattern_pin_oe_o),
   .compare_double_buffer_enable_o(compare_double_buffer_enable_o)
);

// file: testbench/spp_motor.sv
// Motor driver inputs seen through the port pins
`timescale 1ns/10ps
module spp_motor
(
   input wire logic [7:0] pin_i,
   input wire logic [7:0] oe_i,
   output logic [7:0] phase_o
);
   // Pins not given to the pattern fall to the pull-down
   assign phase_o = pin_i & oe_i;
endmodule

// file: testbench/spp_top_test.sv
// Self-checking bench of the stepper pattern port
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
   num_errors++; $display("mismatch %s expected %h seen %h", n, e, g); \
   end end
module spp_top_test;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic ps = 1'b0;
   logic pe = 1'b0;
   logic pw = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pd = 32'h0000_0000;
   logic t01 = 1'b0;
   logic t23 = 1'b0;
   logic wt = 1'b0;
   logic [7:0] fs = 8'h00;
   logic rdy, err, dbo, re;
   logic [31:0] prd, rd;
   logic [7:0] pin, oe, ph, c;
   logic [7:0] ctl = 8'h00;
   logic [7:0] tsl = 8'h00;
   logic [3:0] lat [2] = '{4'h0, 4'h0};
   logic [3:0] alt [2] = '{4'h0, 4'h0};
   int num_errors = 0;
   int n_tests = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   spp_top DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .psel_i(ps), .penable_i(pe), .pwrite_i(pw), .paddr_i(pa),
      .pwdata_i(pd), .pready_o(rdy), .prdata_o(prd), .pslverr_o(err),
      .tmr01_trig_i(t01), .tmr23_trig_i(t23),
      .wide_timer_compare_b_match_i(wt), .port_function_select_i(fs),
      .pattern_pin_o(pin), .pattern_pin_oe_o(oe),
      .compare_double_buffer_enable_o(dbo));
   spp_motor MOTOR (.pin_i(pin), .oe_i(oe), .phase_o(ph));
   // Verdict and end of run
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Reference step of each triggered channel
   task automatic mstep();
      logic [7:0] r;
      logic g;
      for (int k = 0; k < 2; k++)
      begin
         g = ctl[4*k] & (tsl[2+k] ? wt : (k ? t23 : t01));
         r = {lat[k][3], alt[k][3], lat[k][2], alt[k][2],
            lat[k][1], alt[k][1], lat[k][0], alt[k][0]};
         r = ctl[4*k+2] ? {r[0], r[7:1]} : {r[6:0], r[7]};
         if (g && ctl[4*k+1])
            for (int i = 0; i < 4; i++)
               {lat[k][i], alt[k][i]} = r[2*i+:2];
         else if (g)
            lat[k] = ctl[4*k+2] ? {lat[k][0], lat[k][3:1]} :
               {lat[k][2:0], lat[k][3]};
      end
   endtask
   // One APB transfer, answer kept in rd and re
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [7:0] d);
      int k;
      @(posedge ref_clk_i);
      ps <= 1'b1;
      pw <= w;
      pa <= a;
      pd <= {24'h000000, d};
      @(posedge ref_clk_i);
      pe <= 1'b1;
      for (k = 0; k < 8; k++)
      begin
         @(posedge ref_clk_i);
         if (rdy === 1'b1)
            break;
      end
      if (k == 8)
      begin
         num_errors++;
         test_done();
      end
      rd = prd;
      re = err;
      ps <= 1'b0;
      pe <= 1'b0;
   endtask
   // Whole-value write, mirrored into the reference
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
      if (a == 12'h0E8)
         tsl = d & 8'h8D;
      if (a == 12'h138)
         ctl = d;
      if (a[11:3] == 9'h026)
      begin
         alt[a[2]] = d[3:0];
         if (!ctl[4*a[2]+3])
            lat[a[2]] = d[7:4];
      end
   endtask
   // Read compared with the reference
   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK("read", {25'h0000000, e}, {re, rd})
   endtask
   // Random trigger pulses, then pins checked
   task automatic run(input int n);
      repeat (n + 1)
      begin
         @(posedge ref_clk_i);
         mstep();
         {t01, t23, wt} <= 3'($urandom);
      end
      @(posedge ref_clk_i);
      mstep();
      {t01, t23, wt} <= 3'h0;
      @(negedge ref_clk_i);
      `CHK("pins", {lat[1], lat[0]}, pin)
      `CHK("phases", {lat[1], lat[0]} & fs, ph)
   endtask
   // Reset, reset values, a refused address, random traffic
   initial
   begin
      void'($urandom(81356));
      repeat (20) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      foreach (lat[i])
         rchk(12'h130 + 12'(4*i), 8'h00);
      rchk(12'h0E8, 8'h00);
      rchk(12'h138, 8'h00);
      apb(1'b0, 12'h13C, 8'h00);
      `CHK("refused", 33'h1_0000_0000, {re, rd})
      for (int i = 0; i < 60; i++)
      begin
         c = 8'($urandom);
         for (int j = 0; j < 8; j += 4)
            if (c[j+3]) c[j+2-:2] = 2'b01;
         wr(12'h138, c);
         wr(12'h0E8, 8'($urandom) & 8'h0D);
         wr(12'h130, i < 4 ? 8'h10 << i : 8'($urandom));
         wr(12'h134, 8'($urandom));
         fs <= 8'($urandom);
         run(i % 12);
         rchk(12'h130, {lat[0], alt[0]});
         rchk(12'h134, {lat[1], alt[1]});
         `CHK("dbuf", tsl[0], dbo)
      end
      test_done();
   end
endmodule
